// ---- sbac_core.sv ----
// Functional notes
// R1: Four active-low byte parity inputs; low is bad parity, qualified to drive bus fault.
// R2: Two low address bits taken from the bus during a request phase.
// R3: Transceiver direction output valid in every phase, requestor or replier.
// R4: Output lets board logic sense a bus error on the system bus.
// R5: Error interrupt on relevant bus error, timeout or agent error.
// R6: Five two-way register data lines carry register reads and writes.
// R7: Two-bit select picks one of three internal registers.
// R8: Direction input high means write, low means read.
// R9: Output-float test input tristates all outputs; inputs keep working. ctl_par_out, arb_req_out, arb_prio_out, req_out, addr_low_out stay driven.
// R10: Generate control-line parity; check control and address/data parity.
// R11: During bus reset capture IDs from five lines, sixth selects target, strobe qualifies.
// R12: ID capture repeats on every cold and warm reset.
// R13: Reset returns all state machines and state to initial values.
// R14: Arbitration in normal and high priority for either agent.
// R15: Primary requests: all spaces, widths 8 to 32, read/write, block, lock.
// R16: Secondary requests: message space, 32-bit, write only, block and broadcast.
// R17: Replier for primary supports all options and reports agent errors.
// R18: Board logic multiplexes shared priority and agent error inputs.
// R19: Pins synchronous to clock except register port, lock, interrupt, arbitration inputs.
// R20: Asynchronous agents synchronise request, select, ready themselves.
// R21: Error register holds the latest bus error, timeout or agent error.
// R22: Timeout resets arbitration and transfer state, logs error, raises interrupt.
// R23: Read drives selected register onto data lines; write floats and latches them.
module sbac_core
   import sbac_pkg::*;
(
   input wire logic clk_sys,                       // Inverted bus clock
   input wire logic rst_b,                         // Bus reset, active low
   input wire logic bus_reset_act,                 // Bus reset window (cold or warm)
   input wire logic [PAR_BYTES-1:0] byte_parity_ok_n, // Byte parity, low is bad
   input wire logic [1:0] low_addr_bits_n,         // Address bits 1:0, active low
   input wire logic bus_timeout_in,                // Bus timeout
   input wire logic bus_err_in,                    // Bus error seen on system bus
   input wire logic [9:0] ctl_in_n,                // Control lines in, active low
   input wire logic ctl_par_in,                    // Control line parity in
   input wire logic [4:0] arb_in_lines_n,          // Arbitration lines, active low
   input wire logic id_target_select_n,            // Low selects arbitration ID
   input wire logic id_capture_strobe,             // ID capture qualifier
   input wire logic [1:0] agent_bus_req,           // Bus request, bit 1 secondary
   input wire logic prio_high,                     // Shared high priority request
   input wire logic [1:0] agent_handshake_rdy,     // Agent ready, bit 1 secondary
   input wire logic [1:0] agent_target_sel_n,      // Replier selects, active low
   input wire sbac_req_t req_attr_a,               // Primary request attributes
   input wire logic req_bcast_b,                   // Secondary broadcast
   input wire logic [AG_W-1:0] agent_err,          // Shared agent error code
   input wire logic arb_won,                       // Arbitration won this cycle
   input wire logic [REG_W-1:0] reg_port_data_in,  // Register data lines in
   input wire logic [1:0] reg_port_select,         // Register select
   input wire logic reg_port_write_high,           // High writes, low reads
   input wire logic reg_port_strobe,               // Register access strobe
   input wire logic output_float_n,                // Low floats outputs that have a drive enable
   output logic [REG_W-1:0] reg_port_data_out,     // Register data lines out
   output logic reg_port_data_oe,                  // Register data drive enable
   output logic xcvr_direction,                    // High transmits to bus
   output logic xcvr_direction_oe,                 // Drive enable
   output logic bus_fault_sense_n,                 // Bus error sense, active low
   output logic bus_fault_sense_oe,                // Drive enable
   output logic bus_fault_drive,                   // Drive bus error onto bus
   output logic bus_fault_drive_oe,                // Drive enable
   output logic error_irq,                         // Error interrupt to primary
   output logic error_irq_oe,                      // Drive enable
   output logic ctl_par_out,                       // Generated control parity
   output logic [1:0] grant,                       // Grant, bit 1 secondary
   output logic grant_oe,                          // Drive enable
   output logic arb_req_out,                       // Arbitration request to bus
   output logic arb_prio_out,                      // Priority for arbitration
   output sbac_req_t req_out,                      // Request attributes to bus
   output logic [1:0] addr_low_out                 // Captured address low bits
);

   typedef enum logic [2:0] {SBAC_IDLE, SBAC_ARB, SBAC_GRANT, SBAC_XFER, SBAC_REPLY} sbac_st_t;

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   function automatic logic odd_par(input logic [9:0] v);
      odd_par = ~(^v);
   endfunction

   // ------------------------------------------------------------
   // Asynchronous inputs
   // ------------------------------------------------------------
   logic [4:0] arb_sync;
   logic tsel_sync;
   logic strb_sync;
   logic [REG_W-1:0] rdat_sync;
   logic [1:0] rsel_sync;
   logic rwr_sync;
   logic rstb_sync;

   sbac_sync #(.W(7)) u_sync_arb (                 // R19
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .d_in({arb_in_lines_n, id_target_select_n, id_capture_strobe}),
      .q_out({arb_sync, tsel_sync, strb_sync})
   );

   sbac_sync #(.W(REG_W + 4)) u_sync_reg (         // R19
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .d_in({reg_port_data_in, reg_port_select, reg_port_write_high, reg_port_strobe}),
      .q_out({rdat_sync, rsel_sync, rwr_sync, rstb_sync})
   );

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   sbac_st_t st_reg, st_next;
   logic [REG_W-1:0] slot_reg, slot_next;
   logic [REG_W-1:0] arbitration_number_reg, arbitration_number_next;
   logic [REG_W-1:0] err_reg, err_next;
   logic irq_reg, irq_next;
   logic fault_reg, fault_next;
   logic dir_reg, dir_next;
   logic [1:0] grant_reg, grant_next;
   logic owner_b_reg, owner_b_next;
   logic strb_d_reg;
   logic rstb_d_reg;
   logic [1:0] addr_reg, addr_next;
   sbac_req_t req_reg, req_next;
   logic [REG_W-1:0] rdout_reg, rdout_next;
   logic rdoe_reg, rdoe_next;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire id_take = bus_reset_act && strb_sync && !strb_d_reg;           // R11 R12
   wire reg_take = rstb_sync && !rstb_d_reg && !bus_reset_act;
   wire reg_wr = reg_take && rwr_sync;                                 // R8
   wire reg_rd = rstb_sync && !rwr_sync;                               // R8
   wire par_bad = |(~byte_parity_ok_n);                                // R1
   wire ctl_bad = odd_par(ctl_in_n) != ctl_par_in;                     // R10
   wire req_phase = (st_reg == SBAC_XFER);
   wire dat_fault = req_phase && (par_bad || ctl_bad);                 // R1 R10
   wire ag_fault = (st_reg == SBAC_REPLY) && (agent_err != AG_NONE)
                   && agent_handshake_rdy[0];                          // R17
   wire any_err = bus_err_in || bus_timeout_in || ag_fault;            // R5
   wire repl_sel = ~&agent_target_sel_n;
   wire [REG_W-1:0] reg_mux = (rsel_sync == SEL_SLOT) ? slot_reg :
                              (rsel_sync == SEL_ARB) ? arbitration_number_reg :
                              (rsel_sync == SEL_ERR) ? err_reg : '0;   // R7

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      grant_next = grant_reg;
      owner_b_next = owner_b_reg;
      dir_next = dir_reg;
      addr_next = addr_reg;
      req_next = req_reg;
      case (st_reg)
         SBAC_IDLE: begin
            grant_next = 2'h0;
            dir_next = 1'b0;
            if (|agent_bus_req) begin
               st_next = SBAC_ARB;
               owner_b_next = agent_bus_req[1];
            end else if (repl_sel) begin
               st_next = SBAC_REPLY;
            end
         end
         SBAC_ARB: begin
            if (arb_won) begin                                         // R14
               st_next = SBAC_GRANT;
               grant_next = owner_b_reg ? 2'h2 : 2'h1;
               dir_next = 1'b1;                                        // R3
            end
         end
         SBAC_GRANT: begin
            if (agent_handshake_rdy[owner_b_reg]) begin
               st_next = SBAC_XFER;
               addr_next = ~low_addr_bits_n;                           // R2
               if (owner_b_reg) begin
                  req_next.space = SPACE_MSG;                          // R16
                  req_next.width = WIDTH_32;
                  req_next.write = 1'b1;
                  req_next.block = 1'b1;
                  req_next.lock = 1'b0;
                  req_next.bcast = req_bcast_b;
               end else begin
                  req_next = req_attr_a;                               // R15
               end
            end
         end
         SBAC_XFER: begin
            grant_next = 2'h0;
            st_next = SBAC_REPLY;
         end
         SBAC_REPLY: begin
            dir_next = (grant_reg == 2'h0) && !repl_sel ? dir_reg : 1'b0; // R3
            if (agent_handshake_rdy[owner_b_reg] || !repl_sel) begin
               st_next = SBAC_IDLE;
            end
         end
         default: begin
            st_next = SBAC_IDLE;
         end
      endcase
      if (bus_timeout_in) begin                                        // R22
         st_next = SBAC_IDLE;
         grant_next = 2'h0;
         dir_next = 1'b0;
      end
   end

   // Registers and latest-error capture
   always_comb begin
      slot_next = slot_reg;
      arbitration_number_next = arbitration_number_reg;
      err_next = err_reg;
      if (id_take) begin                                               // R11
         if (tsel_sync) begin
            slot_next = ~arb_sync;
         end else begin
            arbitration_number_next = ~arb_sync;
         end
      end else if (reg_wr) begin                                       // R23
         case (rsel_sync)
            SEL_SLOT: slot_next = rdat_sync;
            SEL_ARB: arbitration_number_next = rdat_sync;
            SEL_ERR: err_next = rdat_sync;
            default: err_next = err_reg;
         endcase
      end
      if (any_err || dat_fault) begin                                  // R21 R22
         err_next = '0;
         err_next[ERR_BUS_BIT] = bus_err_in || dat_fault;
         err_next[ERR_TMO_BIT] = bus_timeout_in;
         err_next[ERR_AG_LSB +: AG_W] = ag_fault ? agent_err : AG_NONE;
      end
   end

   assign irq_next = any_err || dat_fault;                             // R5
   assign fault_next = dat_fault;                                      // R1
   assign rdout_next = reg_rd ? reg_mux : rdout_reg;                   // R23
   assign rdoe_next = reg_rd && !bus_reset_act;                        // R23 R6

   // ------------------------------------------------------------
   // Flip-flops
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin                                                // R13
         st_reg <= SBAC_IDLE;
         grant_reg <= 2'h0;
         owner_b_reg <= 1'b0;
         dir_reg <= 1'b0;
         addr_reg <= 2'h0;
         req_reg <= '0;
      end else begin
         st_reg <= st_next;
         grant_reg <= grant_next;
         owner_b_reg <= owner_b_next;
         dir_reg <= dir_next;
         addr_reg <= addr_next;
         req_reg <= req_next;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin                                                // R13
         slot_reg <= SLOT_RST;
         arbitration_number_reg <= ARB_RST;
         err_reg <= ERR_RST;
         irq_reg <= 1'b0;
         fault_reg <= 1'b0;
         strb_d_reg <= 1'b0;
         rstb_d_reg <= 1'b0;
         rdout_reg <= '0;
         rdoe_reg <= 1'b0;
      end else begin
         slot_reg <= slot_next;
         arbitration_number_reg <= arbitration_number_next;
         err_reg <= err_next;
         irq_reg <= irq_next;
         fault_reg <= fault_next;
         strb_d_reg <= strb_sync;
         rstb_d_reg <= rstb_sync;
         rdout_reg <= rdout_next;
         rdoe_reg <= rdoe_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   wire drv_en = output_float_n;                                       // R9
   assign reg_port_data_out = rdout_reg;                               // R6
   assign reg_port_data_oe = rdoe_reg && drv_en;                       // R9 R23
   assign xcvr_direction = dir_reg;                                    // R3
   assign xcvr_direction_oe = drv_en;                                  // R9
   assign bus_fault_sense_n = ~bus_err_in;                             // R4
   assign bus_fault_sense_oe = drv_en;                                 // R9
   assign bus_fault_drive = fault_reg;                                 // R1
   assign bus_fault_drive_oe = drv_en;                                 // R9
   assign error_irq = irq_reg;                                         // R5
   assign error_irq_oe = drv_en;                                       // R9
   assign ctl_par_out = odd_par(ctl_in_n);                             // R10
   assign grant = grant_reg;
   assign grant_oe = drv_en;
   assign arb_req_out = (st_reg == SBAC_ARB);                          // R14
   assign arb_prio_out = (st_reg == SBAC_ARB) && prio_high;            // R14 R18
   assign req_out = req_reg;
   assign addr_low_out = addr_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_irq_on_timeout: assert property (@(posedge clk_sys) disable iff (!rst_b) // R5
      bus_timeout_in |=> error_irq) else $error("irq missing after timeout");
   a_timeout_idle: assert property (@(posedge clk_sys) disable iff (!rst_b) // R22
      bus_timeout_in |=> (st_reg == SBAC_IDLE && grant == 2'h0))
      else $error("timeout did not clear state");
   a_err_tmo_bit: assert property (@(posedge clk_sys) disable iff (!rst_b) // R21
      bus_timeout_in |=> err_reg[ERR_TMO_BIT]) else $error("timeout not logged");
   a_float_outputs: assert property (@(posedge clk_sys) disable iff (!rst_b) // R9
      !output_float_n |-> !(reg_port_data_oe || xcvr_direction_oe || error_irq_oe))
      else $error("output driven while floated");
   a_write_no_drive: assert property (@(posedge clk_sys) disable iff (!rst_b) // R23
      reg_wr |=> !reg_port_data_oe) else $error("data driven during write");
   a_parity_fault: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
      (req_phase && par_bad) |=> bus_fault_drive) else $error("parity fault lost");
   a_sec_msg_only: assert property (@(posedge clk_sys) disable iff (!rst_b) // R16
      (st_reg == SBAC_XFER && owner_b_reg) |-> (req_out.space == SPACE_MSG
      && req_out.width == WIDTH_32 && req_out.write)) else $error("secondary attr bad");
   a_dir_on_grant: assert property (@(posedge clk_sys) disable iff (!rst_b) // R3
      $rose(grant[0] || grant[1]) |-> xcvr_direction) else $error("direction not set");
   a_id_capture: assert property (@(posedge clk_sys) disable iff (!rst_b) // R11
      (id_take && tsel_sync) |=> slot_reg == ~$past(arb_sync))
      else $error("slot id not captured");
   a_fault_sense: assert property (@(posedge clk_sys) disable iff (!rst_b) // R4
      bus_err_in |-> !bus_fault_sense_n) else $error("bus error not sensed");
   a_ctl_par_fault: assert property (@(posedge clk_sys) disable iff (!rst_b) // R10
      (req_phase && ctl_bad) |=> bus_fault_drive) else $error("ctl parity fault lost");
   a_read_drive: assert property (@(posedge clk_sys) disable iff (!rst_b) // R23
      (reg_rd && !bus_reset_act) |=> (reg_port_data_oe || !output_float_n))
      else $error("read data not driven");

endmodule

// ---- sbac_pkg.sv ----
package sbac_pkg;

   // ------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------
   localparam int REG_W = 5;
   localparam logic [1:0] SEL_SLOT = 2'h0;
   localparam logic [1:0] SEL_ARB = 2'h1;
   localparam logic [1:0] SEL_ERR = 2'h2;
   localparam logic [4:0] SLOT_RST = 5'h00;
   localparam logic [4:0] ARB_RST = 5'h00;
   localparam logic [4:0] ERR_RST = 5'h00;

   // ------------------------------------------------------------
   // Error register field positions
   // ------------------------------------------------------------
   localparam int ERR_BUS_BIT = 0;
   localparam int ERR_TMO_BIT = 1;
   localparam int ERR_AG_LSB = 2;
   localparam int AG_W = 3;
   localparam logic [2:0] AG_NONE = 3'h0;

   // ------------------------------------------------------------
   // Request attribute encodings
   // ------------------------------------------------------------
   localparam logic [1:0] SPACE_MSG = 2'h2;
   localparam logic [1:0] WIDTH_32 = 2'h3;
   localparam int PAR_BYTES = 4;
   localparam int SYNC_STAGES = 3;

   typedef enum logic [1:0] {SBAC_SP_MEM, SBAC_SP_IO, SBAC_SP_MSG, SBAC_SP_ICN} sbac_space_t;

   typedef struct packed {
      logic [1:0] space;
      logic [1:0] width;
      logic write;
      logic block;
      logic lock;
      logic bcast;
   } sbac_req_t;

   typedef struct packed {
      logic [REG_W-1:0] data;
      logic oe;
   } sbac_reg_out_t;

endpackage

// ---- sbac_sync.sv ----
module sbac_sync
   import sbac_pkg::*;
#(
   parameter int W = 1
) (
   input wire logic clk_sys,        // System clock
   input wire logic rst_b,          // Async reset, active low
   input wire logic [W-1:0] d_in,   // Asynchronous input
   output logic [W-1:0] q_out       // Filtered, synchronised value
);

   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;

   // Each bit changes on its own once its stages two and three agree
   assign q_next = (s3_reg & ~(s2_reg ^ s3_reg)) | (q_reg & (s2_reg ^ s3_reg));
   assign q_out = q_reg;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         q_reg <= '0;
      end else begin
         s1_reg <= d_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         q_reg <= q_next;
      end
   end

endmodule

// ---- sbac_host_model.sv ----
module sbac_host_model
   import sbac_pkg::*;
(
   input wire logic clk_sys,                 // Clock
   input wire logic host_drive,              // Host drives the register data lines
   input wire logic [REG_W-1:0] host_data,   // Host write data
   input wire logic dev_oe,                  // Device drive enable
   input wire logic [REG_W-1:0] dev_data,    // Device read data
   output logic [REG_W-1:0] wire_data        // Resolved register data lines
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [REG_W-1:0] last_reg;
   wire both_drive = dev_oe & host_drive;
   wire [REG_W-1:0] idle_val = ~last_reg;
   always_ff @(posedge clk_sys) begin
      last_reg <= wire_data;
   end
   // Contention gives unknown; released lines show a changing pattern
   assign wire_data = both_drive ? 'x : (dev_oe ? dev_data : (host_drive ? host_data : idle_val));
endmodule

// ---- tb.sv ----
module tb
   import sbac_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, rst_b, bus_reset_act, bus_timeout_in, bus_err_in, ctl_par_in;
   logic [3:0] byte_parity_ok_n;
   logic [1:0] low_addr_bits_n, agent_bus_req, agent_handshake_rdy, agent_target_sel_n;
   logic [9:0] ctl_in_n;
   logic [4:0] arb_in_lines_n, reg_port_data_in, reg_port_data_out, host_data, v;
   logic id_target_select_n, id_capture_strobe, prio_high, req_bcast_b, arb_won, host_drive;
   logic [AG_W-1:0] agent_err;
   sbac_req_t req_attr_a, req_out;
   logic [1:0] reg_port_select, grant, addr_low_out;
   logic reg_port_write_high, reg_port_strobe, output_float_n, reg_port_data_oe, oe_q;
   logic xcvr_direction, xcvr_direction_oe, bus_fault_sense_n, bus_fault_sense_oe;
   logic bus_fault_drive, bus_fault_drive_oe, error_irq, error_irq_oe, ctl_par_out;
   logic grant_oe, arb_req_out, arb_prio_out;
   logic [4:0] notes[$];
   integer seed = 32'hEEEE;
   int miscompares = 0;
   int checks_done = 0;
   int k;
   sbac_core i_sbac_core (.clk_sys(clk_sys), .rst_b(rst_b), .bus_reset_act(bus_reset_act),
      .byte_parity_ok_n(byte_parity_ok_n), .low_addr_bits_n(low_addr_bits_n),
      .bus_timeout_in(bus_timeout_in), .bus_err_in(bus_err_in), .ctl_in_n(ctl_in_n),
      .ctl_par_in(ctl_par_in), .arb_in_lines_n(arb_in_lines_n),
      .id_target_select_n(id_target_select_n), .id_capture_strobe(id_capture_strobe),
      .agent_bus_req(agent_bus_req), .prio_high(prio_high),
      .agent_handshake_rdy(agent_handshake_rdy), .agent_target_sel_n(agent_target_sel_n),
      .req_attr_a(req_attr_a), .req_bcast_b(req_bcast_b), .agent_err(agent_err),
      .arb_won(arb_won), .reg_port_data_in(reg_port_data_in),
      .reg_port_select(reg_port_select), .reg_port_write_high(reg_port_write_high),
      .reg_port_strobe(reg_port_strobe), .output_float_n(output_float_n),
      .reg_port_data_out(reg_port_data_out), .reg_port_data_oe(reg_port_data_oe),
      .xcvr_direction(xcvr_direction), .xcvr_direction_oe(xcvr_direction_oe),
      .bus_fault_sense_n(bus_fault_sense_n), .bus_fault_sense_oe(bus_fault_sense_oe),
      .bus_fault_drive(bus_fault_drive), .bus_fault_drive_oe(bus_fault_drive_oe),
      .error_irq(error_irq), .error_irq_oe(error_irq_oe), .ctl_par_out(ctl_par_out),
      .grant(grant), .grant_oe(grant_oe), .arb_req_out(arb_req_out),
      .arb_prio_out(arb_prio_out), .req_out(req_out), .addr_low_out(addr_low_out));
   sbac_host_model i_sbac_host_model (.clk_sys(clk_sys), .host_drive(host_drive),
      .host_data(host_data), .dev_oe(reg_port_data_oe), .dev_data(reg_port_data_out),
      .wire_data(reg_port_data_in));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic check(input string name, input logic [4:0] seen, input logic [4:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wait_oe(input logic lvl);
      int n;
      n = 0;
      while (reg_port_data_oe !== lvl && n < 20) begin
         @(negedge clk_sys);
         n++;
      end
      if (n == 20) begin
         miscompares++;
         close_out();
      end
   endtask
   // ------------------------------------------------------------
   // Register port cycles
   // ------------------------------------------------------------
   task automatic reg_read(input logic [1:0] sel, input logic [4:0] exp);
      notes.push_back(exp);
      reg_port_select = sel;
      reg_port_write_high = 1'b0;
      reg_port_strobe = 1'b1;
      wait_oe(1'b1);
      @(negedge clk_sys);
      reg_port_strobe = 1'b0;
      wait_oe(1'b0);
      repeat (5) @(negedge clk_sys);
   endtask
   task automatic reg_write(input logic [1:0] sel, input logic [4:0] d);
      host_drive = 1'b1;
      host_data = d;
      reg_port_select = sel;
      reg_port_write_high = 1'b1;
      reg_port_strobe = 1'b1;
      repeat (8) @(negedge clk_sys);
      check("write_oe", {4'h0, reg_port_data_oe}, 5'h00);
      reg_port_strobe = 1'b0;
      repeat (6) @(negedge clk_sys);
      host_drive = 1'b0;
      reg_port_write_high = 1'b0;
   endtask
   task automatic id_cap(input logic tgt_n, input logic [4:0] id);
      bus_reset_act = 1'b1;
      arb_in_lines_n = ~id;
      id_target_select_n = tgt_n;
      repeat (2) @(negedge clk_sys);
      id_capture_strobe = 1'b1;
      repeat (8) @(negedge clk_sys);
      id_capture_strobe = 1'b0;
      repeat (6) @(negedge clk_sys);
      bus_reset_act = 1'b0;
      repeat (2) @(negedge clk_sys);
   endtask
   task automatic err_event(input logic tmo, input logic [4:0] exp);
      bus_err_in = ~tmo;
      bus_timeout_in = tmo;
      @(negedge clk_sys);
      check("fault_sense", {4'h0, bus_fault_sense_n}, {4'h0, tmo});
      check("irq_on", {4'h0, error_irq}, 5'h01);
      bus_err_in = 1'b0;
      bus_timeout_in = 1'b0;
      repeat (2) @(negedge clk_sys);
      check("irq_off", {4'h0, error_irq}, 5'h00);
      reg_read(SEL_ERR, exp);
   endtask
   // ------------------------------------------------------------
   // Read result monitor
   // ------------------------------------------------------------
   always @(negedge clk_sys) begin
      oe_q <= reg_port_data_oe;
      if (reg_port_data_oe === 1'b1 && oe_q !== 1'b1) begin
         if (notes.size() == 0) check("read_unexpected", 5'h1F, 5'h00);
         else check("read_data", reg_port_data_out, notes.pop_front());
      end
   end
   // Background bus activity that must not disturb the register port
   always @(negedge clk_sys) begin
      ctl_in_n <= 10'($random(seed));
      ctl_par_in <= 1'($random(seed));
      byte_parity_ok_n <= 4'($random(seed));
      low_addr_bits_n <= 2'($random(seed));
      prio_high <= 1'($random(seed));
      req_attr_a <= 8'($random(seed));
      req_bcast_b <= 1'($random(seed));
   end
   initial begin
      {rst_b, bus_reset_act, bus_timeout_in, bus_err_in, id_capture_strobe, arb_won} = '0;
      {reg_port_strobe, reg_port_write_high, host_drive, reg_port_select} = '0;
      {ctl_in_n, ctl_par_in, byte_parity_ok_n, low_addr_bits_n, prio_high} = '0;
      {req_attr_a, req_bcast_b, agent_bus_req, agent_handshake_rdy, agent_err} = '0;
      {arb_in_lines_n, id_target_select_n, agent_target_sel_n} = '1;
      host_data = 5'h00;
      output_float_n = 1'b1;
      oe_q = 1'b0;
      repeat (8) @(negedge clk_sys);
      rst_b = 1'b1;
      @(negedge clk_sys);
      for (k = 0; k < 4; k++) reg_read(2'(k), 5'h00);
      $display("test reset_values done");
      for (k = 0; k < 4; k++) begin
         v = 5'($random(seed));
         reg_write(2'(k), v);
         reg_read(2'(k), (k < 3) ? v : 5'h00);
      end
      $display("test reg_access done");
      err_event(1'b0, 5'h01);
      err_event(1'b1, 5'h02);
      $display("test error_report done");
      id_cap(1'b1, 5'h15);
      reg_read(SEL_SLOT, 5'h15);
      rst_b = 1'b0;
      repeat (2) @(negedge clk_sys);
      rst_b = 1'b1;
      @(negedge clk_sys);
      reg_read(SEL_SLOT, 5'h00);
      id_cap(1'b0, 5'h0A);
      id_cap(1'b1, 5'h1E);
      reg_read(SEL_ARB, 5'h0A);
      reg_read(SEL_SLOT, 5'h1E);
      $display("test id_capture done");
      agent_bus_req = 2'h2;
      @(negedge clk_sys);
      check("arb_req", {4'h0, arb_req_out}, 5'h01);
      arb_won = 1'b1;
      @(negedge clk_sys);
      {arb_won, agent_handshake_rdy} = 3'h2;
      check("grant_dir", {2'h0, grant, xcvr_direction}, 5'h05);
      @(negedge clk_sys);
      {agent_bus_req, agent_handshake_rdy} = '0;
      check("sec_attr", {req_out.space, req_out.width, req_out.write}, {SPACE_MSG, WIDTH_32, 1'b1});
      check("addr_low", {3'h0, addr_low_out}, {3'h0, ~low_addr_bits_n});
      $display("test sec_request done");
      output_float_n = 1'b0;
      @(negedge clk_sys);
      check("float_oe", {xcvr_direction_oe, bus_fault_sense_oe, bus_fault_drive_oe,
         error_irq_oe, grant_oe}, 5'h00);
      output_float_n = 1'b1;
      @(negedge clk_sys);
      check("drive_oe", {xcvr_direction_oe, bus_fault_sense_oe, bus_fault_drive_oe,
         error_irq_oe, grant_oe}, 5'h1F);
      $display("test output_float done");
      close_out();
   end
endmodule
